//--- rtl/sysref_clock_control_map.vh
// Purpose: offsets, fields, resets and timing for the clock control block
// Assumes: 20 MHz reference clock, byte-wide registers
// Notes: included by the clock control register block
`ifndef SYSREF_CLOCK_CONTROL_MAP_VH
`define SYSREF_CLOCK_CONTROL_MAP_VH

// Register addresses (15-bit serial address space)
`define ADDR_SOFT_RESET 15'h0000
`define ADDR_CAPTURE_CTRL 15'h0029
`define ADDR_CLOCK_INPUT 15'h002a
`define ADDR_SAMPLE_TUNE 15'h002b
`define ADDR_EDGE_POS_LO 15'h002c
`define ADDR_EDGE_POS_MID 15'h002d
`define ADDR_EDGE_POS_HI 15'h002e

// Reset values
`define RST_CAPTURE_CTRL 8'h00
`define RST_CLOCK_INPUT 8'h00
`define RST_SAMPLE_TUNE 8'h11

// Soft reset register field
`define BIT_SOFT_RESET 7

// Capture control fields
`define BIT_PROCESSOR_ON 6
`define BIT_RECEIVER_ON 5
`define BIT_FINE_STEP 4
`define FLD_DELAY_HI 3
`define FLD_DELAY_LO 0

// Clock input control fields
`define BIT_SYSREF_TS 3
`define BIT_CLK_PECL 2
`define BIT_SYSREF_PECL 1
`define BIT_POLARITY_FLIP 0

// Sample clock tuning fields
`define BIT_FEEDBACK_GAIN 4
`define BIT_NOISE_SUPPRESS 2
`define FLD_SAMPLE_DLY_HI 1
`define FLD_SAMPLE_DLY_LO 0

// Serial frame layout
`define FRAME_HEADER_BITS 5'd16
`define FRAME_LAST_BIT 5'd23

// Soft reset quiet time
`define CLK_PERIOD_NS 50
`define SOFT_RESET_NS 750
// 750 ns at 50 ns per cycle, sized to the quiet counter
`define SOFT_RESET_CYCLES 5'd15

`endif

//--- rtl/sysref_clock_control_regs.v
// Purpose: clock and SYSREF control registers behind a serial control port
// Assumes: serial pins sampled on i_ref_clk, sclk well below clock rate
// Notes: one 24-bit frame per access, read flag first, no streaming
`timescale 1ns/10ps
`include "sysref_clock_control_map.vh"

module sysref_clock_control_regs (
  // Clock, reset, enable
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire i_clk_en,
  // Serial control port
  input wire i_spi_cs_n,
  input wire i_spi_sclk,
  input wire i_spi_sdi,
  output reg o_spi_sdo,
  output reg o_spi_sdo_oe_n,
  // SYSREF path
  input wire i_sysref,
  input wire [23:0] i_edge_position_status,
  output reg o_sysref_event,
  // Timestamp on sample LSB
  input wire i_timestamp_enable,
  input wire i_decimation_bypass,
  input wire i_sample_lsb,
  output reg o_sample_lsb,
  // Capture control fields
  output reg o_sysref_processor_on,
  output reg o_sysref_receiver_on,
  output reg o_window_fine_step,
  output reg [3:0] o_capture_delay_choice,
  // Clock input control fields
  output reg o_sysref_as_timestamp,
  output reg o_clock_input_pecl_mode,
  output reg o_sysref_input_pecl_mode,
  output reg o_sysref_polarity_flip,
  // Sample clock tuning fields
  output reg o_feedback_gain_high,
  output reg o_supply_noise_suppress,
  output reg [1:0] o_sample_clock_delay,
  // Soft reset in progress
  output reg o_soft_reset_busy
);

  // Register file and serial state
  reg [7:0] capture_ctrl_q;
  reg [7:0] clock_input_q;
  reg [7:0] sample_tune_q;
  reg [22:0] shift_q;
  reg [4:0] bit_cnt_q;
  reg [7:0] tx_q;
  reg sclk_q;
  reg [4:0] quiet_cnt_q;
  reg sysref_q;
  // Read flag kept apart, the shifter carries it away on the last rise
  reg read_frame_q;

  // Frame layout, first bit on the wire first:
  //   bit 23      read flag, one for a read
  //   bits 22..8  register address, most significant first
  //   bits 7..0   write data, or don't-care on a read
  // Read data leaves on the falls after the sixteenth rise, so the
  // master sees each bit settled before the rise that takes it.
  // A frame cut short by the select going high leaves no trace: the
  // bit counter restarts and nothing is committed.
  // While the soft reset settles every frame is dropped whole; a
  // master that ignores the quiet time loses its access silently.
  // Limitation: no streaming, one byte per selected frame only.

  wire sclk_rise;
  wire sclk_fall;
  wire frame_active;
  wire [14:0] hdr_addr;
  wire [14:0] wr_addr;
  wire [7:0] wr_data;
  wire wr_commit;
  wire soft_reset_hit;
  wire sysref_aligned;
  wire ts_carry;

  // Read data for one address; unmapped reads return zero
  function [7:0] read_byte;
    input [14:0] addr;
    input [7:0] cap;
    input [7:0] cin;
    input [7:0] tun;
    input [23:0] pos;
    begin
      case (addr)
        `ADDR_CAPTURE_CTRL: read_byte = cap;
        `ADDR_CLOCK_INPUT: read_byte = cin;
        `ADDR_SAMPLE_TUNE: read_byte = tun;
        `ADDR_EDGE_POS_LO: read_byte = pos[7:0];
        `ADDR_EDGE_POS_MID: read_byte = pos[15:8];
        `ADDR_EDGE_POS_HI: read_byte = pos[23:16];
        default: read_byte = 8'h00;
      endcase
    end
  endfunction

  // Serial edge detection on the sampled clock pin
  assign sclk_rise = i_spi_sclk & ~sclk_q;
  assign sclk_fall = ~i_spi_sclk & sclk_q;
  // Frames are ignored while the soft reset settles
  assign frame_active = ~i_spi_cs_n & ~o_soft_reset_busy;

  // Header as seen on the sixteenth rising edge
  assign hdr_addr = {shift_q[13:0], i_spi_sdi};
  // Write fields as seen on the last rising edge
  // Flag sits in bit 22, address in 21..7, data in 6..0 plus the pin
  assign wr_addr = shift_q[21:7];
  assign wr_data = {shift_q[6:0], i_spi_sdi};
  assign wr_commit = frame_active & sclk_rise & (bit_cnt_q == `FRAME_LAST_BIT)
    & ~shift_q[22];
  assign soft_reset_hit = wr_commit & (wr_addr == `ADDR_SOFT_RESET)
    & wr_data[`BIT_SOFT_RESET];

  // Serial shifter, bit counter and read data
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_q <= 1'b0;
      shift_q <= 23'h000000;
      bit_cnt_q <= 5'h00;
      tx_q <= 8'h00;
      o_spi_sdo <= 1'b0;
      o_spi_sdo_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      sclk_q <= i_spi_sclk;
      if (!frame_active) begin
        // Deselect ends any partial frame
        bit_cnt_q <= 5'h00;
        o_spi_sdo_oe_n <= 1'b1;
      end else begin
        if (sclk_rise) begin
          shift_q <= {shift_q[21:0], i_spi_sdi};
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == `FRAME_HEADER_BITS - 5'd1) begin
            tx_q <= read_byte(hdr_addr, capture_ctrl_q, clock_input_q,
              sample_tune_q, i_edge_position_status);
          end
        end
        // Read data leaves on falling edges after the header
        if (sclk_fall && bit_cnt_q >= `FRAME_HEADER_BITS && read_frame_q) begin
          o_spi_sdo <= tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
          o_spi_sdo_oe_n <= 1'b0;
        end
      end
    end
  end

  // Read flag taken on the first rise and held to the end of the frame
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      read_frame_q <= 1'b0;
    end else if (i_clk_en) begin
      if (!frame_active) begin
        // Cleared between frames so a stale read never drives the pin
        read_frame_q <= 1'b0;
      end else if (sclk_rise && bit_cnt_q == 5'h00) begin
        read_frame_q <= i_spi_sdi;
      end
    end
  end

  // Quiet counter after a soft reset
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      quiet_cnt_q <= 5'h00;
      o_soft_reset_busy <= 1'b0;
    end else if (i_clk_en) begin
      if (soft_reset_hit) begin
        quiet_cnt_q <= `SOFT_RESET_CYCLES;
        o_soft_reset_busy <= 1'b1;
      end else if (quiet_cnt_q != 5'h00) begin
        quiet_cnt_q <= quiet_cnt_q - 5'h01;
        o_soft_reset_busy <= (quiet_cnt_q != 5'h01);
      end
    end
  end

  // Control registers; soft reset restores defaults, bit itself self-clears
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      capture_ctrl_q <= `RST_CAPTURE_CTRL;
      clock_input_q <= `RST_CLOCK_INPUT;
      sample_tune_q <= `RST_SAMPLE_TUNE;
    end else if (i_clk_en) begin
      if (soft_reset_hit) begin
        capture_ctrl_q <= `RST_CAPTURE_CTRL;
        clock_input_q <= `RST_CLOCK_INPUT;
        sample_tune_q <= `RST_SAMPLE_TUNE;
      end else if (wr_commit) begin
        // Whole bytes stored, reserved bits included
        // Status and unmapped addresses fall through untouched
        if (wr_addr == `ADDR_CAPTURE_CTRL) begin
          capture_ctrl_q <= wr_data;
        end
        if (wr_addr == `ADDR_CLOCK_INPUT) begin
          clock_input_q <= wr_data;
        end
        if (wr_addr == `ADDR_SAMPLE_TUNE) begin
          sample_tune_q <= wr_data;
        end
      end
    end
  end

  // Field outputs, one cycle behind the register file
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sysref_processor_on <= 1'b0;
      o_sysref_receiver_on <= 1'b0;
      o_window_fine_step <= 1'b0;
      o_capture_delay_choice <= 4'h0;
      o_sysref_as_timestamp <= 1'b0;
      o_clock_input_pecl_mode <= 1'b0;
      o_sysref_input_pecl_mode <= 1'b0;
      o_sysref_polarity_flip <= 1'b0;
      o_feedback_gain_high <= 1'b1;
      o_supply_noise_suppress <= 1'b0;
      o_sample_clock_delay <= 2'h1;
    end else if (i_clk_en) begin
      o_sysref_processor_on <= capture_ctrl_q[`BIT_PROCESSOR_ON];
      o_sysref_receiver_on <= capture_ctrl_q[`BIT_RECEIVER_ON];
      o_window_fine_step <= capture_ctrl_q[`BIT_FINE_STEP];
      o_capture_delay_choice <=
        capture_ctrl_q[`FLD_DELAY_HI:`FLD_DELAY_LO];
      o_sysref_as_timestamp <= clock_input_q[`BIT_SYSREF_TS];
      o_clock_input_pecl_mode <= clock_input_q[`BIT_CLK_PECL];
      o_sysref_input_pecl_mode <= clock_input_q[`BIT_SYSREF_PECL];
      o_sysref_polarity_flip <= clock_input_q[`BIT_POLARITY_FLIP];
      o_feedback_gain_high <= sample_tune_q[`BIT_FEEDBACK_GAIN];
      o_supply_noise_suppress <= sample_tune_q[`BIT_NOISE_SUPPRESS];
      o_sample_clock_delay <=
        sample_tune_q[`FLD_SAMPLE_DLY_HI:`FLD_SAMPLE_DLY_LO];
    end
  end

  // SYSREF after the receiver and the polarity selector
  assign sysref_aligned = (i_sysref ^ clock_input_q[`BIT_POLARITY_FLIP])
    & capture_ctrl_q[`BIT_RECEIVER_ON];
  // Timestamp path only exists with the down-converter bypassed
  assign ts_carry = clock_input_q[`BIT_SYSREF_TS] & i_timestamp_enable
    & i_decimation_bypass;

  // SYSREF event detect and sample LSB substitution
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sysref_q <= 1'b0;
      o_sysref_event <= 1'b0;
      o_sample_lsb <= 1'b0;
    end else if (i_clk_en) begin
      sysref_q <= sysref_aligned;
      // Rising edge only counts while the processor runs
      o_sysref_event <= sysref_aligned & ~sysref_q
        & capture_ctrl_q[`BIT_PROCESSOR_ON];
      o_sample_lsb <= ts_carry ? sysref_aligned : i_sample_lsb;
    end
  end

endmodule

//--- sim/sysref_clock_source.sv
// Purpose: clock generator model that drives the SYSREF level
// Assumes: launch requests arrive just after a clock edge
// Notes: SYSREF idles low between pulses, as a real source does
`timescale 1ns/10ps
module sysref_clock_source (
  // Launch request
  input wire logic i_ref_clk,
  input wire logic i_fire,
  // SYSREF level
  output logic o_sysref
);
  logic [2:0] cnt_q = 3'h0;
  initial o_sysref = 1'b0;
  // Four-cycle pulse, long enough for a one-stage sync
  always @(posedge i_ref_clk) begin
    if (i_fire) cnt_q <= 3'h4;
    else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
    o_sysref <= i_fire || cnt_q > 3'h1;
  end
endmodule

//--- sim/sysref_clock_control_props.sv
// Purpose: port assertions for the clock control registers
// Assumes: clock enable held high
// Notes: bound to the design top below
`timescale 1ns/10ps
module sysref_clock_control_props (
  // Watched ports
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_spi_cs_n,
  input wire logic i_timestamp_enable,
  input wire logic i_decimation_bypass,
  input wire logic i_sample_lsb,
  input wire logic o_sample_lsb,
  input wire logic o_sysref_event,
  input wire logic o_sysref_processor_on,
  input wire logic [3:0] o_capture_delay_choice,
  input wire logic o_sysref_polarity_flip,
  input wire logic o_feedback_gain_high,
  input wire logic [1:0] o_sample_clock_delay,
  input wire logic o_soft_reset_busy
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // Defaults present at the first edge after release
  rst_dflt_a: assert property ($fell(i_sys_rst) |->
    o_feedback_gain_high && o_sample_clock_delay == 2'h1) else $error("bad reset value");
  event_pulse_a: assert property (o_sysref_event |=> !o_sysref_event)
    else $error("event too long");
  // Processor bit may have flipped one cycle before
  event_gate_a: assert property (o_sysref_event |->
    o_sysref_processor_on || $past(o_sysref_processor_on)) else $error("event while off");
  lsb_pass_a: assert property (!i_decimation_bypass |=>
    o_sample_lsb == $past(i_sample_lsb)) else $error("lsb not passed");
  lsb_stamp_a: assert property (!i_timestamp_enable |=>
    o_sample_lsb == $past(i_sample_lsb)) else $error("lsb not passed");
  busy_len_a: assert property ($rose(o_soft_reset_busy) |->
    o_soft_reset_busy[*8] ##1 o_soft_reset_busy[*7] ##1 !o_soft_reset_busy)
    else $error("busy length wrong");
  busy_dflt_a: assert property ($rose(o_soft_reset_busy) |=>
    o_feedback_gain_high && !o_sysref_processor_on && o_capture_delay_choice == 4'h0)
    else $error("soft reset missed");
  // Fields only move through a frame
  hold_a: assert property (i_spi_cs_n[*3] |->
    $stable(o_capture_delay_choice) && $stable(o_sysref_polarity_flip))
    else $error("field moved idle");
endmodule
bind sysref_clock_control_regs sysref_clock_control_props u_props (.i_ref_clk, .i_sys_rst,
  .i_spi_cs_n, .i_timestamp_enable, .i_decimation_bypass, .i_sample_lsb, .o_sample_lsb,
  .o_sysref_event, .o_sysref_processor_on, .o_capture_delay_choice, .o_sysref_polarity_flip,
  .o_feedback_gain_high, .o_sample_clock_delay, .o_soft_reset_busy);

//--- sim/sysref_clock_control_regs_bench.sv
// Purpose: serial register tests for the clock control block
// Assumes: 20 MHz clock, inputs moved 5 ns after the edge
// Notes: sclk phases are 3 cycles, above the 2-cycle minimum
`timescale 1ns/10ps
module sysref_clock_control_regs_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n = 1'b1;
  logic sclk = 1'b0;
  logic sdi = 1'b0;
  logic fire = 1'b0;
  logic ts_en = 1'b1;
  logic bypass = 1'b1;
  logic slsb = 1'b0;
  logic [23:0] pos = 24'ha5c33c;
  logic [15:0] ev = 16'h0000;
  wire sdo, oe_n, sysref, event_o, lsb_o, busy;
  logic oe_lo = 1'b1;
  wire [15:1] f;
  integer mismatches = 0;
  integer checks = 0;
  integer cycles = 0;
  integer tn = 1;
  integer k;
  // Free-running reference clock
  always #25 clk = ~clk;
  sysref_clock_source u_sysref_clock_source (.i_ref_clk(clk), .i_fire(fire), .o_sysref(sysref));
  sysref_clock_control_regs u_sysref_clock_control_regs (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_clk_en(1'b1), .i_spi_cs_n(cs_n), .i_spi_sclk(sclk), .i_spi_sdi(sdi), .o_spi_sdo(sdo),
    .o_spi_sdo_oe_n(oe_n), .i_sysref(sysref), .i_edge_position_status(pos),
    .o_sysref_event(event_o), .i_timestamp_enable(ts_en), .i_decimation_bypass(bypass),
    .i_sample_lsb(slsb), .o_sample_lsb(lsb_o), .o_sysref_processor_on(f[15]),
    .o_sysref_receiver_on(f[14]), .o_window_fine_step(f[13]), .o_capture_delay_choice(f[12:9]),
    .o_sysref_as_timestamp(f[8]), .o_clock_input_pecl_mode(f[7]),
    .o_sysref_input_pecl_mode(f[6]), .o_sysref_polarity_flip(f[5]),
    .o_feedback_gain_high(f[4]), .o_supply_noise_suppress(f[3]),
    .o_sample_clock_delay(f[2:1]), .o_soft_reset_busy(busy));
  // Event count and hang guard
  always @(posedge clk) begin
    cycles++;
    if (event_o === 1'b1) ev <= ev + 16'h0001;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic cyc(input integer n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One frame, read bits taken just before each rise
  task automatic xfer(input logic [23:0] fr, output logic [7:0] r);
    cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi = fr[i];
      cyc(3);
      if (i < 8) r[i] = sdo;
      if (i == 0) oe_lo = oe_n;
      sclk = 1'b1;
      cyc(3);
      sclk = 1'b0;
    end
    cyc(3);
    cs_n = 1'b1;
    cyc(3);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer({1'b0, a, d}, r);
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    logic [7:0] r;
    xfer({1'b1, a, 8'h00}, r);
    chk({8'h00, r}, {8'h00, e});
    chk({15'h0000, oe_lo}, 16'h0000);
  endtask
  // Field outputs expected from the three register values
  function automatic logic [15:0] fx(input logic [7:0] c, input logic [7:0] n, input logic [7:0] t);
    return {c[6:0], n[3:0], t[4], t[2:0], 1'b0};
  endfunction
  task automatic pulse;
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
  endtask
  task automatic tend;
    $display("test %0d done", tn);
    tn++;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    cyc(12);
    rst = 1'b0;
    cyc(1);
    rd(15'h029, 8'h00);
    rd(15'h02a, 8'h00);
    rd(15'h02b, 8'h11);
    chk({f, 1'b0}, fx(8'h00, 8'h00, 8'h11));
    pulse();
    cyc(8);
    chk(ev, 16'h0000);
    tend();
    wr(15'h029, 8'h20);
    wr(15'h029, 8'heb);
    wr(15'h02a, 8'hfa);
    wr(15'h02b, 8'he6);
    rd(15'h029, 8'heb);
    rd(15'h02a, 8'hfa);
    rd(15'h02b, 8'he6);
    chk({f, 1'b0}, fx(8'heb, 8'hfa, 8'he6));
    tend();
    pulse();
    cyc(2);
    chk({15'h0000, lsb_o}, 16'h0001);
    cyc(6);
    chk(ev, 16'h0001);
    bypass = 1'b0;
    pulse();
    cyc(2);
    chk({15'h0000, lsb_o}, 16'h0000);
    tend();
    rd(15'h02c, 8'h3c);
    rd(15'h02d, 8'hc3);
    rd(15'h02e, 8'ha5);
    wr(15'h02c, 8'hff);
    rd(15'h02c, 8'h3c);
    rd(15'h040, 8'h00);
    tend();
    wr(15'h000, 8'h80);
    chk({15'h0000, busy}, 16'h0001);
    for (k = 0; k < 40 && busy !== 1'b0; k++) cyc(1);
    rd(15'h029, 8'h00);
    rd(15'h02b, 8'h11);
    chk({f, 1'b0}, fx(8'h00, 8'h00, 8'h11));
    tend();
    // Receiver first, then processor with zoom and delay zero
    wr(15'h029, 8'h30);
    wr(15'h029, 8'h70);
    // Flipping an idle-low SYSREF makes one rising edge
    wr(15'h02a, 8'h01);
    chk({f, 1'b0}, fx(8'h70, 8'h01, 8'h11));
    chk(ev, 16'h0003);
    tend();
    test_done();
  end
endmodule
